//--- design/gcr_pkg.sv
package gcr_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int NUM_LINES = 8;
  localparam int NUM_DED = 4;
  localparam int NUM_DUAL = 8;
  localparam int NUM_ROW = 6;
  localparam int NUM_LAB = 2;
  localparam int NUM_PLL = 2;
  localparam int PER_W = 16;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_LINE_SEL = 8'h00;
  localparam logic [7:0] OFS_PIN_CFG = 8'h04;
  localparam logic [7:0] OFS_PIN_IN = 8'h08;
  localparam logic [7:0] OFS_PLL0 = 8'h0c;
  localparam logic [7:0] OFS_PLL1 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_INT_STAT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1c;
  localparam logic [7:0] OFS_ROW_SEL = 8'h20;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PIN_GLB_LSB = 0;
  localparam int PIN_OE_LSB = 8;
  localparam int PIN_OUT_LSB = 16;
  localparam int PLL_RUN_BIT = 0;
  localparam int PLL_CLR_BIT = 1;
  localparam int PLL_PFD_BIT = 2;
  localparam int PLL_M_LSB = 8;
  localparam int PLL_N_LSB = 16;
  localparam int PLL_HA_LSB = 24;
  localparam int PLL_HB_LSB = 28;
  localparam int ROW_SEL_W = 3;
  localparam int LAB_SEL_LSB = 18;
  localparam int INT_W = 6;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] LINE_SEL_RST = 16'h0000;
  localparam logic [23:0] PIN_CFG_RST = 24'h00_0000;
  localparam logic [31:0] PLL_CTL_RST = 32'h1101_0104;
  localparam logic [23:0] ROW_SEL_RST = 24'h22_c688;
  localparam logic [5:0] INT_MASK_RST = 6'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
  localparam int VCO_MIN_KHZ = 500;
  localparam int VCO_MAX_KHZ = 50000;
  localparam int LOCK_EDGES = 4;
  localparam int LOCK_MIN = 2;
  localparam int LOCK_MAX = 10;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {SRC_DED, SRC_DUAL, SRC_PLL, SRC_INT}
    gcr_src_type;
  typedef enum logic [1:0] {PLL_OFF, PLL_ACQ, PLL_LOCK, PLL_HOLD}
    gcr_pll_state_type;
endpackage

//--- design/gcr_pll.sv
`timescale 1ns/1ps
`default_nettype none
module gcr_pll (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // reference and controls
  input wire logic ref_clk,
  input wire logic run_en,
  input wire logic async_clr,
  input wire logic pfd_en,
  input wire logic [7:0] mult,
  input wire logic [7:0] divn,
  input wire logic [3:0] half_a,
  input wire logic [3:0] half_b,
  // results
  output logic post_counter_a,
  output logic post_counter_b,
  output logic locked,
  output logic range_ok
);
  gcr_pkg::gcr_pll_state_type state;
  logic ref_q, ref_edge, halted, seen, ok;
  logic [15:0] cnt;
  logic [3:0] edges;
  logic [3:0] hcnt [2];
  logic [3:0] half [2];
  logic pclk [2];
  logic [47:0] vco_lhs, vco_lo, vco_hi;

  assign halted = !run_en || async_clr;
  assign ref_edge = ref_clk && !ref_q;
  assign vco_lhs = 48'(mult) * 48'(gcr_pkg::CLK_KHZ);
  assign vco_lo = 48'(gcr_pkg::VCO_MIN_KHZ) * 48'(cnt) * 48'(divn);
  assign vco_hi = 48'(gcr_pkg::VCO_MAX_KHZ) * 48'(cnt) * 48'(divn);
  // fin * m / n inside the vco range, fin = clk / cnt
  assign ok = seen && (cnt != 16'h0000) &&
              (vco_lhs >= vco_lo) && (vco_lhs <= vco_hi);
  // ----------------------------------------
  // reference period
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_clk;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
      seen <= 1'b0;
    end else if (halted) begin
      cnt <= 16'h0000;
      seen <= 1'b0;
    end else if (ref_edge) begin
      cnt <= 16'h0001;
      seen <= 1'b1;
    end else if (cnt != 16'hffff) begin
      cnt <= cnt + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_ok <= 1'b0;
    end else if (halted) begin
      range_ok <= 1'b0;
    end else if (ref_edge) begin
      range_ok <= ok;
    end
  end
  // ----------------------------------------
  // lock state
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= gcr_pkg::PLL_OFF;
      locked <= 1'b0;
      edges <= 4'h0;
    end else if (halted) begin
      state <= gcr_pkg::PLL_OFF;
      locked <= 1'b0;
      edges <= 4'h0;
    end else begin
      case (state)
        gcr_pkg::PLL_OFF: begin
          state <= gcr_pkg::PLL_ACQ;
          edges <= 4'h0;
        end
        gcr_pkg::PLL_ACQ: begin
          if (!pfd_en) begin
            state <= gcr_pkg::PLL_HOLD;
          end else if (ref_edge && !ok) begin
            edges <= 4'h0;
          end else if (ref_edge) begin
            if (edges == 4'(gcr_pkg::LOCK_EDGES - 1)) begin
              state <= gcr_pkg::PLL_LOCK;
              locked <= 1'b1;
            end else begin
              edges <= edges + 4'h1;
            end
          end
        end
        gcr_pkg::PLL_LOCK: begin
          if (!pfd_en) begin
            state <= gcr_pkg::PLL_HOLD;
          end else if (ref_edge && !ok) begin
            state <= gcr_pkg::PLL_ACQ;
            locked <= 1'b0;
            edges <= 4'h0;
          end
        end
        default: begin
          // lock flag frozen while the detector is off
          if (pfd_en) begin
            state <= gcr_pkg::PLL_ACQ;
            locked <= 1'b0;
            edges <= 4'h0;
          end
        end
      endcase
    end
  end
  // ----------------------------------------
  // post-scale counters
  // ----------------------------------------
  assign half[0] = half_a;
  assign half[1] = half_b;

  for (genvar k = 0; k < 2; k++) begin : g_post
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        hcnt[k] <= 4'h0;
        pclk[k] <= 1'b0;
      end else if (halted) begin
        hcnt[k] <= 4'h0;
        pclk[k] <= 1'b0;
      end else if (hcnt[k] == half[k]) begin
        hcnt[k] <= 4'h0;
        pclk[k] <= !pclk[k];
      end else begin
        hcnt[k] <= hcnt[k] + 4'h1;
      end
    end
  end

  assign post_counter_a = pclk[0];
  assign post_counter_b = pclk[1];
  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [3:0] acq_edges;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acq_edges <= 4'h0;
    end else if (halted || state != gcr_pkg::PLL_ACQ) begin
      acq_edges <= 4'h0;
    end else if (ref_edge) begin
      acq_edges <= (seen && !ok) ? 4'h0 : acq_edges + 4'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_free_run;
    !pfd_en && !halted ##1 !pfd_en && !halted;
  endsequence
  sequence s_release;
    $fell(async_clr) && run_en ##1 run_en && !async_clr;
  endsequence

  property p_run_low;
    !run_en |=> !locked && !post_counter_a && !post_counter_b;
  endproperty
  a_run_low: assert property (p_run_low)
    else $error("outputs active while run is low");
  property p_clr_high;
    async_clr |=> !locked && !post_counter_a && !post_counter_b;
  endproperty
  a_clr_high: assert property (p_clr_high)
    else $error("outputs active while clear is high");
  property p_pfd_hold;
    s_free_run |-> $stable(locked);
  endproperty
  a_pfd_hold: assert property (p_pfd_hold)
    else $error("lock moved while detector off");
  property p_lock_time;
    $rose(locked) |-> acq_edges >= 4'(gcr_pkg::LOCK_MIN) &&
                      acq_edges <= 4'(gcr_pkg::LOCK_MAX);
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("lock outside 2 to 10 input cycles");
  property p_range_drop;
    ref_edge && seen && !ok && !halted && pfd_en |=> !locked;
  endproperty
  a_range_drop: assert property (p_range_drop)
    else $error("lock kept with vco out of range");
  property p_clr_release;
    s_release |-> state == gcr_pkg::PLL_ACQ && edges == 4'h0;
  endproperty
  a_clr_release: assert property (p_clr_release)
    else $error("acquisition did not restart");
endmodule
`default_nettype wire

//--- design/gcr_top.sv
`timescale 1ns/1ps
`default_nettype none
module gcr_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // clock pins
  input wire logic [3:0] ded_clk_in,
  input wire logic [7:0] dual_use_clock_pins_in,
  output logic [7:0] dual_use_clock_pins_out,
  output logic [7:0] dual_use_clock_pins_oe,
  // internal logic sources, one per line
  input wire logic [7:0] internal_sources,
  // distribution
  output logic [7:0] global_lines,
  output logic [5:0] row_clocks,
  output logic [1:0] lab_clocks,
  output logic [1:0] pll_locked,
  output logic irq
);
  // ----------------------------------------
  // fixed source maps
  // ----------------------------------------
  function automatic logic [1:0] ded_of(input int l);
    case (l)
      0, 2: ded_of = 2'h0;
      1, 3: ded_of = 2'h1;
      4, 6: ded_of = 2'h2;
      default: ded_of = 2'h3;
    endcase
  endfunction

  function automatic logic [2:0] dual_of(input int l);
    case (l)
      0: dual_of = 3'h2;
      1: dual_of = 3'h7;
      2: dual_of = 3'h1;
      3: dual_of = 3'h0;
      4: dual_of = 3'h3;
      5: dual_of = 3'h6;
      6: dual_of = 3'h4;
      default: dual_of = 3'h5;
    endcase
  endfunction

  // index into {pll1 b, pll1 a, pll0 b, pll0 a}
  function automatic logic [1:0] pll_of(input int l);
    case (l)
      1, 2: pll_of = 2'h0;
      0, 3: pll_of = 2'h1;
      5, 6: pll_of = 2'h2;
      default: pll_of = 2'h3;
    endcase
  endfunction
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [11:0] pin_s1, pin_s2, pin_s3, pin_f;
  logic [3:0] ded_f;
  logic [7:0] dual_f;
  logic addr_ok, wr_pend, rd_pend;
  logic [7:0] acc_addr;
  logic we_line, we_pin, we_row, we_istat, we_imask;
  logic [15:0] line_sel;
  logic [23:0] pin_cfg;
  logic [7:0] pin_glb;
  logic [31:0] pll_ctl [gcr_pkg::NUM_PLL];
  logic [23:0] row_sel;
  logic [5:0] int_stat, int_mask, int_ev, int_clr;
  logic [3:0] pll_clk;
  logic [1:0] pll_rng, lock_q, rng_q;
  logic [7:0] next_lines;
  logic [5:0] next_rows;
  logic [1:0] next_labs;
  logic [31:0] rd_word;

  assign ded_f = pin_f[3:0];
  assign dual_f = pin_f[11:4];
  assign pin_glb = pin_cfg[gcr_pkg::PIN_GLB_LSB +: 8];
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 12'h000;
      pin_s2 <= 12'h000;
      pin_s3 <= 12'h000;
      pin_f <= 12'h000;
    end else begin
      pin_s1 <= {dual_use_clock_pins_in, ded_clk_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      // a bit moves only once stages two and three agree
      pin_f <= (~(pin_s2 ^ pin_s3) & pin_s3) |
               ((pin_s2 ^ pin_s3) & pin_f);
    end
  end
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;
  assign we_line = wr_pend && (acc_addr == gcr_pkg::OFS_LINE_SEL);
  assign we_pin = wr_pend && (acc_addr == gcr_pkg::OFS_PIN_CFG);
  assign we_row = wr_pend && (acc_addr == gcr_pkg::OFS_ROW_SEL);
  assign we_istat = wr_pend && (acc_addr == gcr_pkg::OFS_INT_STAT);
  assign we_imask = wr_pend && (acc_addr == gcr_pkg::OFS_INT_MASK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      acc_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      rd_pend <= addr_ok && !hwrite;
      if (addr_ok) begin
        acc_addr <= haddr[7:0];
      end
    end
  end

  // reads take one wait state so the data come from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hreadyout <= !(addr_ok && !hwrite);
      hresp <= 1'b0;
      if (rd_pend) begin
        hrdata <= rd_word;
      end
    end
  end

  always_comb begin
    if (acc_addr == gcr_pkg::OFS_LINE_SEL) begin
      rd_word = {16'h0000, line_sel};
    end else if (acc_addr == gcr_pkg::OFS_PIN_CFG) begin
      rd_word = {8'h00, pin_cfg};
    end else if (acc_addr == gcr_pkg::OFS_PIN_IN) begin
      rd_word = {20'h0_0000, pin_f};
    end else if (acc_addr == gcr_pkg::OFS_PLL0) begin
      rd_word = pll_ctl[0];
    end else if (acc_addr == gcr_pkg::OFS_PLL1) begin
      rd_word = pll_ctl[1];
    end else if (acc_addr == gcr_pkg::OFS_STATUS) begin
      rd_word = {28'h000_0000, pll_rng, pll_locked};
    end else if (acc_addr == gcr_pkg::OFS_INT_STAT) begin
      rd_word = {26'h000_0000, int_stat};
    end else if (acc_addr == gcr_pkg::OFS_INT_MASK) begin
      rd_word = {26'h000_0000, int_mask};
    end else if (acc_addr == gcr_pkg::OFS_ROW_SEL) begin
      rd_word = {8'h00, row_sel};
    end else begin
      rd_word = 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_sel <= gcr_pkg::LINE_SEL_RST;
    end else if (we_line) begin
      line_sel <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cfg <= gcr_pkg::PIN_CFG_RST;
    end else if (we_pin) begin
      pin_cfg <= hwdata[23:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_sel <= gcr_pkg::ROW_SEL_RST;
    end else if (we_row) begin
      row_sel <= hwdata[23:0];
    end
  end

  for (genvar k = 0; k < gcr_pkg::NUM_PLL; k++) begin : g_ctl
    localparam logic [7:0] OFS = 8'(gcr_pkg::OFS_PLL0 + 4 * k);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pll_ctl[k] <= gcr_pkg::PLL_CTL_RST;
      end else if (wr_pend && acc_addr == OFS) begin
        pll_ctl[k] <= hwdata;
      end
    end
  end
  // ----------------------------------------
  // gpio side of dual-use pins
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dual_use_clock_pins_out <= 8'h00;
      dual_use_clock_pins_oe <= 8'h00;
    end else begin
      dual_use_clock_pins_out <= pin_cfg[gcr_pkg::PIN_OUT_LSB +: 8];
      dual_use_clock_pins_oe <=
        pin_cfg[gcr_pkg::PIN_OE_LSB +: 8] & ~pin_glb;
    end
  end
  // ----------------------------------------
  // PLLs
  // ----------------------------------------
  for (genvar k = 0; k < gcr_pkg::NUM_PLL; k++) begin : g_pll
    gcr_pll u_pll (
      .hclk(hclk),
      .hresetn(hresetn),
      .ref_clk(ded_f[2 * k]),
      .run_en(pll_ctl[k][gcr_pkg::PLL_RUN_BIT]),
      .async_clr(pll_ctl[k][gcr_pkg::PLL_CLR_BIT]),
      .pfd_en(pll_ctl[k][gcr_pkg::PLL_PFD_BIT]),
      .mult(pll_ctl[k][gcr_pkg::PLL_M_LSB +: 8]),
      .divn(pll_ctl[k][gcr_pkg::PLL_N_LSB +: 8]),
      .half_a(pll_ctl[k][gcr_pkg::PLL_HA_LSB +: 4]),
      .half_b(pll_ctl[k][gcr_pkg::PLL_HB_LSB +: 4]),
      .post_counter_a(pll_clk[2 * k]),
      .post_counter_b(pll_clk[2 * k + 1]),
      .locked(pll_locked[k]),
      .range_ok(pll_rng[k])
    );
  end
  // ----------------------------------------
  // global lines
  // ----------------------------------------
  for (genvar l = 0; l < gcr_pkg::NUM_LINES; l++) begin : g_line
    logic nl;
    always_comb begin
      case (gcr_pkg::gcr_src_type'(line_sel[2 * l +: 2]))
        gcr_pkg::SRC_DED: nl = ded_f[ded_of(l)];
        gcr_pkg::SRC_DUAL: nl = dual_f[dual_of(l)] &
                                pin_glb[dual_of(l)];
        gcr_pkg::SRC_PLL: nl = pll_clk[pll_of(l)];
        default: nl = internal_sources[l];
      endcase
    end
    assign next_lines[l] = nl;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_lines <= 8'h00;
    end else begin
      global_lines <= next_lines;
    end
  end
  // ----------------------------------------
  // row and lab clocks
  // ----------------------------------------
  for (genvar r = 0; r < gcr_pkg::NUM_ROW; r++) begin : g_row
    assign next_rows[r] =
      global_lines[row_sel[gcr_pkg::ROW_SEL_W * r +: 3]];
  end

  for (genvar j = 0; j < gcr_pkg::NUM_LAB; j++) begin : g_lab
    logic [2:0] lsel;
    assign lsel = row_sel[gcr_pkg::LAB_SEL_LSB + 3 * j +: 3];
    assign next_labs[j] = (lsel < 3'h6) ? row_clocks[lsel] : 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      row_clocks <= 6'h00;
      lab_clocks <= 2'h0;
    end else begin
      row_clocks <= next_rows;
      lab_clocks <= next_labs;
    end
  end
  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign int_ev = {rng_q & ~pll_rng, lock_q & ~pll_locked,
                   pll_locked & ~lock_q};
  assign int_clr = we_istat ? hwdata[5:0] : 6'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 2'h0;
      rng_q <= 2'h0;
    end else begin
      lock_q <= pll_locked;
      rng_q <= pll_rng;
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat <= 6'h00;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask <= gcr_pkg::INT_MASK_RST;
    end else if (we_imask) begin
      int_mask <= hwdata[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_line0_ded;
    line_sel[1:0] == gcr_pkg::SRC_DED |=>
      global_lines[0] == $past(ded_f[0]);
  endproperty
  a_line0_ded: assert property (p_line0_ded)
    else $error("line 0 not fed by dedicated input 0");
  property p_line5_ded;
    line_sel[11:10] == gcr_pkg::SRC_DED |=>
      global_lines[5] == $past(ded_f[3]);
  endproperty
  a_line5_ded: assert property (p_line5_ded)
    else $error("line 5 not fed by dedicated input 3");
  property p_line3_dual;
    line_sel[7:6] == gcr_pkg::SRC_DUAL |=>
      global_lines[3] == $past(dual_f[0] && pin_glb[0]);
  endproperty
  a_line3_dual: assert property (p_line3_dual)
    else $error("line 3 not fed by dual-use pin 0");
  property p_line1_pll;
    line_sel[3:2] == gcr_pkg::SRC_PLL |=>
      global_lines[1] == $past(pll_clk[0]);
  endproperty
  a_line1_pll: assert property (p_line1_pll)
    else $error("line 1 not fed by first PLL counter a");
  property p_line7_int;
    line_sel[15:14] == gcr_pkg::SRC_INT |=>
      global_lines[7] == $past(internal_sources[7]);
  endproperty
  a_line7_int: assert property (p_line7_int)
    else $error("line 7 not fed by internal logic");
  property p_gpio_oe;
    pin_glb[2] |=> !dual_use_clock_pins_oe[2];
  endproperty
  a_gpio_oe: assert property (p_gpio_oe)
    else $error("pin driven while used as global source");
  property p_row0;
    $stable(row_sel) |=>
      row_clocks[0] == $past(global_lines[row_sel[2:0]]);
  endproperty
  a_row0: assert property (p_row0)
    else $error("row clock 0 does not follow its line");
  // per bit: a filtered level moves only where stages two and three agreed
  property p_sync;
    ((pin_f ^ $past(pin_f)) & $past(pin_s2 ^ pin_s3)) == 12'h000;
  endproperty
  a_sync: assert property (p_sync)
    else $error("pin level accepted before stages agree");
  property p_irq;
    irq |-> $past(|(int_stat & int_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without unmasked status");
  property p_read;
    addr_ok && !hwrite |=> s_read_wait;
  endproperty
  a_read: assert property (p_read)
    else $error("read not answered after one wait state");
endmodule
`default_nettype wire

//--- testbench/gcr_board.sv
`timescale 1ns/1ps
`default_nettype none
module gcr_board (
  // clock
  input wire logic hclk,
  // control
  input wire logic ref_on,
  input wire logic [3:0] lvl,
  // pins
  output logic [3:0] ded_clk_in
);
  logic [2:0] cnt = 3'h0;
  // inputs 0 and 2 carry the loop references when enabled
  always_ff @(posedge hclk) begin
    cnt <= cnt + 3'h1;
    ded_clk_in <= ref_on ? {lvl[3], cnt[2], lvl[1], cnt[2]} : lvl;
  end
endmodule
`default_nettype wire

//--- testbench/test_global_clock_routing_pll_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_global_clock_routing_pll_control;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ref_on = 0;
  logic hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, r, seed = 32'h59;
  logic [1:0] htrans = 0, pll_locked, lab_clocks;
  logic [7:0] din = 0, intl = 0, dout, doe, gl, e;
  logic [3:0] lvl = 0, ded;
  logic [5:0] rows;
  logic [15:0] sel[4] = '{16'h0000, 16'h5555, 16'hffff, 16'haaaa};
  int err_total = 0, tests_run = 0, cyc = 0, n;
  always #50 hclk = ~hclk;
  gcr_board u_brd (.hclk, .ref_on, .lvl, .ded_clk_in(ded));
  gcr_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .ded_clk_in(ded), .dual_use_clock_pins_in(din),
    .dual_use_clock_pins_out(dout), .dual_use_clock_pins_oe(doe),
    .internal_sources(intl), .global_lines(gl), .row_clocks(rows),
    .lab_clocks, .pll_locked, .irq);
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] model(logic [15:0] s);
    int dm[8] = '{0, 1, 0, 1, 2, 3, 2, 3};
    int pm[8] = '{2, 7, 1, 0, 3, 6, 4, 5};
    for (int l = 0; l < 8; l++) begin
      case (s[2*l+:2])
        2'h0: model[l] = lvl[dm[l]];
        2'h1: model[l] = din[pm[l]];
        2'h2: model[l] = 1'b0;
        default: model[l] = intl[l];
      endcase
    end
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk iff hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk iff hreadyout);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_lock();
    n = 0;
    while (pll_locked[0] !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    tick(12);
    hresetn <= 1'b1;
    tick(1);
    rd(8'h0c, 32'h1101_0104);
    rd(8'h20, 32'h0022_c688);
    rd(8'h40, 32'h0);
    chk(hresp, 0);
    bus(1'b1, 8'h04, 32'h00a5_ff0f);
    tick(2);
    chk({dout, doe}, 16'ha5f0);
    bus(1'b1, 8'h04, 32'h0000_00ff);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h00, {16'h0, sel[s]});
      repeat (3) begin
        r = xs();
        lvl <= r[3:0];
        din <= r[11:4];
        intl <= r[19:12];
        // board flop, three sync stages, filter flop, line, row and lab flops
        tick(10);
        e = model(sel[s]);
        chk(gl, e);
        chk({rows, lab_clocks}, {e[5:0], e[1:0]});
      end
    end
    ref_on <= 1'b1;
    bus(1'b1, 8'h0c, 32'h1101_0105);
    wait_lock();
    chk(n >= 16 && n <= 88, 1);
    chk(irq, 0);
    bus(1'b1, 8'h1c, 32'h1);
    tick(2);
    chk(irq, 1);
    bus(1'b1, 8'h18, 32'h1);
    tick(2);
    chk(irq, 0);
    bus(1'b1, 8'h0c, 32'h1101_0107);
    tick(2);
    chk(pll_locked, 0);
    bus(1'b1, 8'h0c, 32'h1101_0105);
    wait_lock();
    chk(n <= 88, 1);
    bus(1'b1, 8'h0c, 32'h1101_0101);
    tick(4);
    r = gl;
    tick(2);
    chk(gl[3:0] ^ r[3:0], 4'hf);
    chk(pll_locked[0], 1);
    bus(1'b1, 8'h0c, 32'h1101_0105);
    tick(2);
    chk(pll_locked[0], 0);
    wait_lock();
    chk(pll_locked[0], 1);
    bus(1'b1, 8'h0c, 32'h1101_0104);
    tick(2);
    chk(pll_locked, 0);
    tick(1);
    chk(gl, 8'h00);
    bus(1'b1, 8'h0c, 32'h1101_ff05);
    tick(100);
    rd(8'h14, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
